// ===== common/dual_comparator_control_map.svh
// Register indices, field positions, reset values and mode codes of the comparator control
`ifndef DUAL_COMPARATOR_CONTROL_MAP_SVH
`define DUAL_COMPARATOR_CONTROL_MAP_SVH

// ********************************
// Register indices (byte address = index * 4)
// ********************************
`define DCC_IDX_PORT_A_DATA      8'h05
`define DCC_IDX_INTERRUPT_CTL    8'h0b
`define DCC_IDX_IRQ_FLAGS        8'h0c
`define DCC_IDX_COMPARATOR_CTL   8'h1f
`define DCC_IDX_IRQ_STATUS       8'h40
`define DCC_IDX_IRQ_MASK         8'h41
`define DCC_IDX_PORT_A_DIR       8'h85
`define DCC_IDX_IRQ_ENABLE       8'h8c
`define DCC_IDX_VREF_CTL         8'h9f

// ********************************
// Field positions
// ********************************
`define DCC_BIT_GLOBAL_EN        7
`define DCC_BIT_PERIPH_EN        6
`define DCC_BIT_CMP_FLAG         6
`define DCC_BIT_CMP_ENABLE       6
`define DCC_BIT_SECOND_RESULT    7
`define DCC_BIT_FIRST_RESULT     6

// ********************************
// Reset values and writable masks
// ********************************
`define DCC_RST_INTERRUPT_CTL    8'h00
`define DCC_RST_COMPARATOR_CTL   4'h0
`define DCC_RST_PORT_A_DIR       5'h1f
`define DCC_RST_VREF_CTL         8'h00
`define DCC_MASK_VREF_CTL        8'hef

// ********************************
// Comparator mode codes
// ********************************
`define DCC_MODE_RESET           3'h0
`define DCC_MODE_INTERNAL_REF    3'h2
`define DCC_MODE_SHARED_REF      3'h3
`define DCC_MODE_ONE_COMPARATOR  3'h5
`define DCC_MODE_PIN_OUTPUT      3'h6
`define DCC_MODE_OFF             3'h7

`endif

// ===== common/dual_comparator_control_pkg.sv
// Types shared by the comparator control block and its bench
package dual_comparator_control_pkg;

   // Controls driven into the analog comparator pair
   typedef struct packed {
      logic       powerDown;      // Both comparators off
      logic       refToNoninv;    // Internal reference on both non-inverting inputs
      logic       inputSwitch;    // Input switch select
      logic [2:0] modeField;      // Comparator mode field
   } analog_ctl_t;

   // Controls driven into the voltage reference
   typedef struct packed {
      logic       enable;         // Ladder powered
      logic       outputEnable;   // Reference onto pin two
      logic       lowRange;       // Range select
      logic [3:0] level;          // Tap select
   } vref_ctl_t;

endpackage

// ===== design/dual_comparator_control.sv
// Control, status and interrupt logic around two analog comparators
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dual_comparator_control_map.svh"

// Function
// - Mode 010 puts internal reference on non-inverting inputs
// - Result bits are read-only live comparator outputs
// - Mode 110 drives raw outputs on pins three, four
// - Direction bits still enable those pin drivers
// - Analog pins read zero from port data
// - Any output change sets comparator interrupt flag
// - Writing zero clears flag, one sets it
// - Request needs all three enables; flag sets anyway
// - Any control register access ends the mismatch
// - Persisting mismatch keeps setting the flag
// - Comparators run in sleep; enabled interrupt wakes
// - Mode 111 turns both comparators off
// - Waking leaves control register untouched
// - Reset returns control register, mode 000
// - Comparators powered down throughout reset
// - Output high when non-inverting input is higher
module dual_comparator_control (
   input  wire logic                                     core_clk,
   input  wire logic                                     reset,
   input  wire logic [9:0]                               address,
   input  wire logic                                     read,
   input  wire logic                                     write,
   input  wire logic [31:0]                              writedata,
   input  wire logic [3:0]                               byteenable,
   output logic [31:0]                                   readdata,
   output logic                                          waitrequest,
   input  wire logic [1:0]                               comparatorRaw,
   input  wire logic                                     sleepMode,
   input  wire logic [4:0]                               portPinIn,
   output logic [4:0]                                    portPinOut,
   output logic [4:0]                                    portPinOe,
   output dual_comparator_control_pkg::analog_ctl_t      analogCtl,
   output dual_comparator_control_pkg::vref_ctl_t        vrefCtl,
   output logic                                          cmpIrqRequest,
   output logic                                          wakeRequest,
   output logic                                          irq
);

   // ********************************
   // Decode helpers
   // ********************************

   // Comparators powered in this mode
   function automatic logic modePowered(input logic [2:0] mode);
      modePowered = (mode != `DCC_MODE_RESET) && (mode != `DCC_MODE_OFF);
   endfunction

   // Pins zero to three that are analog inputs in this mode
   function automatic logic [3:0] analogMask(input logic [2:0] mode);
      unique case (mode)
         `DCC_MODE_OFF:           analogMask = 4'h0;
         `DCC_MODE_SHARED_REF,
         `DCC_MODE_PIN_OUTPUT:    analogMask = 4'h7;
         `DCC_MODE_ONE_COMPARATOR: analogMask = 4'h3;
         default:                 analogMask = 4'hf;
      endcase
   endfunction

   // ********************************
   // Synchronisers
   // ********************************
   logic [1:0] compMeta;     // First stage, comparator outputs
   logic [1:0] compSync;     // Second stage, comparator outputs
   logic [4:0] pinMeta;      // First stage, port pins
   logic [4:0] pinSync;      // Second stage, port pins

   // Two flops ahead of all logic except the pin-mode mux, which takes comparatorRaw directly
   always_ff @(posedge core_clk) begin
      compMeta <= comparatorRaw;
      compSync <= compMeta;
      pinMeta  <= portPinIn;
      pinSync  <= pinMeta;
   end

   // ********************************
   // Register state
   // ********************************
   logic [7:0] interruptCtl;  // Global and peripheral enables
   logic       cmpFlag;       // Comparator interrupt flag
   logic       cmpEnable;     // Comparator interrupt enable
   logic [3:0] comparatorCtl; // Input switch and mode field
   logic [4:0] portDir;       // Port direction, one is input
   logic [4:0] portLatch;     // Port output data
   logic [7:0] vrefReg;       // Reference control
   logic [1:0] latchedResult; // Copy taken at last access
   logic [1:0] prevResult;    // Result one cycle ago
   logic [1:0] irqStatus;     // Sticky change events
   logic [1:0] irqMask;       // Event mask

   // ********************************
   // Bus decode
   // ********************************
   logic       busReq;        // Read or write pending
   logic       accept;        // Access completes this edge
   logic [7:0] regIndex;      // Word index
   logic       wrLow;         // Write with low byte enabled
   logic       cmpAccess;     // Control register touched
   logic [2:0] mode;          // Current mode field
   logic       powered;       // Comparators running
   logic [1:0] result;        // Live synced results
   logic       mismatch;      // Results differ from copy
   logic [1:0] change;        // Result edges

   assign busReq    = read | write;
   assign accept    = busReq & ~waitrequest;
   assign regIndex  = address[9:2];
   assign wrLow     = accept & write & byteenable[0];
   assign cmpAccess = accept & (regIndex == `DCC_IDX_COMPARATOR_CTL);
   assign mode      = comparatorCtl[2:0];
   assign powered   = modePowered(mode);
   assign result    = compSync & {2{powered}};
   assign mismatch  = |(result ^ latchedResult);
   assign change    = result ^ prevResult;

   // One wait state, then completion
   always_ff @(posedge core_clk) begin
      if (reset) begin
         waitrequest <= 1'b1;
      end else if (busReq && waitrequest) begin
         waitrequest <= 1'b0;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // ********************************
   // Register writes
   // ********************************

   // Interrupt control
   always_ff @(posedge core_clk) begin
      if (reset) begin
         interruptCtl <= `DCC_RST_INTERRUPT_CTL;
      end else if (wrLow && regIndex == `DCC_IDX_INTERRUPT_CTL) begin
         interruptCtl <= writedata[7:0];
      end
   end

   // Comparator control; sleep does not touch it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         comparatorCtl <= `DCC_RST_COMPARATOR_CTL;
      end else if (wrLow && regIndex == `DCC_IDX_COMPARATOR_CTL) begin
         comparatorCtl <= writedata[3:0];
      end
   end

   // Comparator interrupt enable
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmpEnable <= 1'b0;
      end else if (wrLow && regIndex == `DCC_IDX_IRQ_ENABLE) begin
         cmpEnable <= writedata[`DCC_BIT_CMP_ENABLE];
      end
   end

   // Port direction and output data
   always_ff @(posedge core_clk) begin
      if (reset) begin
         portDir   <= `DCC_RST_PORT_A_DIR;
         portLatch <= 5'h00;
      end else begin
         if (wrLow && regIndex == `DCC_IDX_PORT_A_DIR) begin
            portDir <= writedata[4:0];
         end
         if (wrLow && regIndex == `DCC_IDX_PORT_A_DATA) begin
            portLatch <= writedata[4:0];
         end
      end
   end

   // Reference control, bit four unimplemented
   always_ff @(posedge core_clk) begin
      if (reset) begin
         vrefReg <= `DCC_RST_VREF_CTL;
      end else if (wrLow && regIndex == `DCC_IDX_VREF_CTL) begin
         vrefReg <= writedata[7:0] & `DCC_MASK_VREF_CTL;
      end
   end

   // ********************************
   // Mismatch and comparator flag
   // ********************************

   // Copy results on any control register access
   always_ff @(posedge core_clk) begin
      if (reset) begin
         latchedResult <= 2'h0;
      end else if (cmpAccess) begin
         latchedResult <= result;
      end
   end

   // Flag: mismatch sets, software writes; set wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmpFlag <= 1'b0;
      end else if (wrLow && regIndex == `DCC_IDX_IRQ_FLAGS) begin
         cmpFlag <= writedata[`DCC_BIT_CMP_FLAG] | mismatch;
      end else if (mismatch) begin
         cmpFlag <= 1'b1;
      end
   end

   // ********************************
   // Change events, status and mask
   // ********************************

   // Previous result for edge detection
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prevResult <= 2'h0;
      end else begin
         prevResult <= result;
      end
   end

   // Sticky status, write one clears, set wins
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irqStatus <= 2'h0;
      end else if (wrLow && regIndex == `DCC_IDX_IRQ_STATUS) begin
         irqStatus <= (irqStatus & ~writedata[1:0]) | change;
      end else begin
         irqStatus <= irqStatus | change;
      end
   end

   // Event mask
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irqMask <= 2'h0;
      end else if (wrLow && regIndex == `DCC_IDX_IRQ_MASK) begin
         irqMask <= writedata[1:0];
      end
   end

   // ********************************
   // Read path
   // ********************************
   logic [7:0] readByte;      // Selected register value

   // Register read mux, unmapped reads zero
   always_comb begin
      readByte = 8'h00;
      unique case (regIndex)
         `DCC_IDX_PORT_A_DATA:    readByte = {3'h0, pinSync & ~{1'b0, analogMask(mode)}};
         `DCC_IDX_INTERRUPT_CTL:  readByte = interruptCtl;
         `DCC_IDX_IRQ_FLAGS:      readByte = {1'b0, cmpFlag, 6'h00};
         `DCC_IDX_COMPARATOR_CTL: readByte = {result[1], result[0], 2'h0, comparatorCtl};
         `DCC_IDX_IRQ_STATUS:     readByte = {6'h00, irqStatus};
         `DCC_IDX_IRQ_MASK:       readByte = {6'h00, irqMask};
         `DCC_IDX_PORT_A_DIR:     readByte = {3'h0, portDir};
         `DCC_IDX_IRQ_ENABLE:     readByte = {1'b0, cmpEnable, 6'h00};
         `DCC_IDX_VREF_CTL:       readByte = vrefReg;
         default:                 readByte = 8'h00;
      endcase
   end

   // Read data loaded in the wait cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (busReq && waitrequest) begin
         readdata <= {24'h00_0000, readByte};
      end
   end

   // ********************************
   // Analog and reference controls
   // ********************************

   // Powered down during reset and off modes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         analogCtl.powerDown   <= 1'b1;
         analogCtl.refToNoninv <= 1'b0;
         analogCtl.inputSwitch <= 1'b0;
         analogCtl.modeField   <= `DCC_MODE_RESET;
      end else begin
         analogCtl.powerDown   <= ~powered;
         analogCtl.refToNoninv <= (mode == `DCC_MODE_INTERNAL_REF);
         analogCtl.inputSwitch <= comparatorCtl[3];
         analogCtl.modeField   <= mode;
      end
   end

   // Reference module controls
   always_ff @(posedge core_clk) begin
      if (reset) begin
         vrefCtl <= '0;
      end else begin
         vrefCtl.enable       <= vrefReg[7];
         vrefCtl.outputEnable <= vrefReg[6];
         vrefCtl.lowRange     <= vrefReg[5];
         vrefCtl.level        <= vrefReg[3:0];
      end
   end

   // ********************************
   // Port pin drivers
   // ********************************

   // Direction bit low drives the pin
   always_ff @(posedge core_clk) begin
      if (reset) begin
         portPinOe <= 5'h00;
      end else begin
         portPinOe <= ~portDir;
      end
   end

   // Raw comparator outputs bypass the latch in pin mode
   always_comb begin
      portPinOut = portLatch;
      if (mode == `DCC_MODE_PIN_OUTPUT) begin
         portPinOut[3] = comparatorRaw[0];
         portPinOut[4] = comparatorRaw[1];
      end
   end

   // ********************************
   // Interrupt outputs
   // ********************************

   // Request, wake and event interrupt
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cmpIrqRequest <= 1'b0;
         wakeRequest   <= 1'b0;
         irq           <= 1'b0;
      end else begin
         cmpIrqRequest <= cmpFlag & cmpEnable & interruptCtl[`DCC_BIT_PERIPH_EN]
                          & interruptCtl[`DCC_BIT_GLOBAL_EN];
         wakeRequest   <= sleepMode & cmpFlag & cmpEnable
                          & interruptCtl[`DCC_BIT_PERIPH_EN];
         irq           <= |(irqStatus & irqMask);
      end
   end

endmodule
`default_nettype wire

// ===== verif/comparator_pair_model.sv
// Behavioural pair of analog comparators facing the control block
`timescale 1ns/1ps
`default_nettype none
module comparator_pair_model (
   input wire dual_comparator_control_pkg::analog_ctl_t analogCtl,     // Controls in
   input wire logic [7:0]                               refLevel,      // Internal reference
   input wire logic [15:0]                              noninvPin,     // Plus pin levels
   input wire logic [15:0]                              invPin,        // Minus pin levels
   output logic [1:0]                                   comparatorRaw  // Raw outputs
);
   logic [15:0] plusIn; // Level on each plus input
   // Reference replaces both plus inputs in reference mode
   assign plusIn = analogCtl.refToNoninv ? {2{refLevel}} : noninvPin;
   // High while plus exceeds minus; powered-down parts idle low; sleep ignored
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         comparatorRaw[i] = !analogCtl.powerDown && (plusIn[8*i+:8] > invPin[8*i+:8]);
      end
   end
endmodule
`default_nettype wire

// ===== verif/dual_comparator_control_props.sv
// Port-level checks for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_props (
   input wire logic                                     core_clk,      // Core clock
   input wire logic                                     reset,         // Sync reset
   input wire logic                                     read,          // Bus read strobe
   input wire logic                                     write,         // Bus write strobe
   input wire logic [31:0]                              readdata,      // Bus read data
   input wire logic                                     waitrequest,   // Bus stall
   input wire logic [1:0]                               comparatorRaw, // Raw outputs
   input wire logic                                     sleepMode,     // Sleep level
   input wire logic [4:0]                               portPinOut,    // Pin values
   input wire dual_comparator_control_pkg::analog_ctl_t analogCtl,     // Analog controls
   input wire logic                                     wakeRequest    // Wake level
);
   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // Request seen while stalled
   sequence reqWaiting;
      (read || write) && waitrequest;
   endsequence
   // Exactly one cycle of acknowledge
   sequence ackOnce;
      !waitrequest ##1 waitrequest;
   endsequence
   one_wait_a: assert property (reqWaiting |=> ackOnce)
      else $error("bus answer not one wait cycle");
   ack_has_req_a: assert property (!waitrequest |-> (read || write))
      else $error("acknowledge without request");
   read_upper_a: assert property (readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   pin_mux_a: assert property (analogCtl.modeField == 3'h6 |->
      ($past(portPinOut) & 5'h18) == {$past(comparatorRaw), 3'h0})
      else $error("pins three and four not raw outputs");
   reset_off_a: assert property ($past(reset) |->
      analogCtl.powerDown && analogCtl.modeField == 3'h0)
      else $error("comparators not off after reset");
   ref_select_a: assert property (analogCtl.refToNoninv == (analogCtl.modeField == 3'h2))
      else $error("reference routing wrong");
   off_mode_a: assert property (analogCtl.modeField == 3'h7 |-> analogCtl.powerDown)
      else $error("off mode leaves comparators on");
   wake_sleep_a: assert property (wakeRequest |-> $past(sleepMode))
      else $error("wake outside sleep");
   ctl_hold_a: assert property (!$past(write) && !$past(write, 2) && !$past(reset)
      |-> $stable(analogCtl))
      else $error("controls changed without write");
endmodule
bind dual_comparator_control dual_comparator_control_props u_props (
   .core_clk(core_clk), .reset(reset), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest), .comparatorRaw(comparatorRaw),
   .sleepMode(sleepMode), .portPinOut(portPinOut), .analogCtl(analogCtl),
   .wakeRequest(wakeRequest)
);
`default_nettype wire

// ===== verif/dual_comparator_control_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_tb;
   logic core_clk = 0, reset = 1, read = 0, write = 0, sleepMode = 0;
   logic [9:0] address = 10'h0;
   logic [31:0] writedata = 32'h0, readdata;
   logic [1:0] comparatorRaw;
   logic [4:0] portPinIn = 5'h0, portPinOut, portPinOe;
   logic [7:0] refLevel = 8'h80, junk;
   logic [15:0] noninvPin = 16'h0, invPin = 16'hffff;
   logic waitrequest, cmpIrqRequest, wakeRequest, irq;
   logic [3:0] byteenable = 4'hf;
   dual_comparator_control_pkg::analog_ctl_t analogCtl;
   dual_comparator_control_pkg::vref_ctl_t vrefCtl;
   int fails = 0, cmp_count = 0;
   dual_comparator_control u_dut (.core_clk(core_clk), .reset(reset), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .comparatorRaw(comparatorRaw),
      .sleepMode(sleepMode), .portPinIn(portPinIn), .portPinOut(portPinOut),
      .portPinOe(portPinOe), .analogCtl(analogCtl), .vrefCtl(vrefCtl),
      .cmpIrqRequest(cmpIrqRequest), .wakeRequest(wakeRequest), .irq(irq));
   comparator_pair_model u_model (.analogCtl(analogCtl), .refLevel(refLevel),
      .noninvPin(noninvPin), .invPin(invPin), .comparatorRaw(comparatorRaw));
   // ****************
   // Tasks
   // ****************
   // Clock at 100 MHz
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus cycle, held until the stall drops
   task automatic acc(input logic isWrite, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      @(posedge core_clk);
      address <= {idx, 2'b00};
      read <= !isWrite;
      write <= isWrite;
      writedata <= {24'h0, wd};
      do @(posedge core_clk); while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      acc(1'b1, idx, d, junk);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h0, junk);
      chk(junk, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pulse_reset;
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
   endtask
   task automatic test_done;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      rdc(8'h1f, 8'h00);
      rdc(8'h85, 8'h1f);
      rdc(8'h0c, 8'h00);
      rdc(8'h33, 8'h00);
      chk(analogCtl.powerDown, 1'b1);
      $display("reset values done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 8; m++) begin
         wr(8'h1f, 8'(m));
         settle(2);
         chk(analogCtl.refToNoninv, m == 2);
         chk(analogCtl.powerDown, m == 0 || m == 7);
      end
      wr(8'h9f, 8'hff);
      rdc(8'h9f, 8'hef);
      chk(vrefCtl, 7'h7f);
      byteenable <= 4'he;
      wr(8'h9f, 8'h00);
      byteenable <= 4'hf;
      rdc(8'h9f, 8'hef);
      wr(8'h1f, 8'h08);
      settle(2);
      chk(analogCtl.inputSwitch, 1'b1);
      $display("modes done");
   endtask
   task automatic t_results;
      wr(8'h1f, 8'h02);
      invPin <= 16'hff10;
      settle(4);
      rdc(8'h1f, 8'h42);
      wr(8'h1f, 8'hc2);
      rdc(8'h1f, 8'h42);
      invPin <= 16'h10ff;
      settle(4);
      rdc(8'h1f, 8'h82);
      $display("results done");
   endtask
   task automatic t_pins;
      wr(8'h85, 8'h07);
      wr(8'h1f, 8'h06);
      portPinIn <= 5'h1f;
      noninvPin <= 16'h5050;
      invPin <= 16'h9010;
      settle(4);
      chk(portPinOut[4:3], 2'b01);
      chk(portPinOe, 5'h18);
      rdc(8'h05, 8'h18);
      @(posedge core_clk);
      invPin <= 16'h1090;
      settle(1);
      chk(portPinOut[4:3], 2'b10);
      wr(8'h1f, 8'h00);
      rdc(8'h05, 8'h10);
      wr(8'h05, 8'h15);
      settle(1);
      chk(portPinOut, 5'h15);
      $display("pins done");
   endtask
   task automatic t_irq;
      wr(8'h1f, 8'h02);
      invPin <= 16'hffff;
      wr(8'h0b, 8'hc0);
      wr(8'h8c, 8'h40);
      rdc(8'h1f, 8'h02);
      wr(8'h0c, 8'h00);
      wr(8'h40, 8'h03);
      rdc(8'h0c, 8'h00);
      invPin <= 16'hff10;
      settle(5);
      rdc(8'h0c, 8'h40);
      chk(cmpIrqRequest, 1'b1);
      wr(8'h0c, 8'h00);
      rdc(8'h0c, 8'h40);
      rdc(8'h1f, 8'h42);
      wr(8'h0c, 8'h00);
      rdc(8'h0c, 8'h00);
      wr(8'h0c, 8'h40);
      rdc(8'h0c, 8'h40);
      wr(8'h0b, 8'h40);
      settle(2);
      chk(cmpIrqRequest, 1'b0);
      rdc(8'h0c, 8'h40);
      sleepMode <= 1'b1;
      settle(3);
      chk(wakeRequest, 1'b1);
      rdc(8'h1f, 8'h42);
      sleepMode <= 1'b0;
      wr(8'h41, 8'h00);
      settle(2);
      chk(irq, 1'b0);
      wr(8'h41, 8'h01);
      settle(2);
      chk(irq, 1'b1);
      wr(8'h40, 8'h01);
      settle(2);
      chk(irq, 1'b0);
      $display("interrupts done");
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      test_done();
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      t_reset();
      t_modes();
      t_results();
      t_pins();
      t_irq();
      wr(8'h1f, 8'h06);
      pulse_reset();
      t_reset();
      test_done();
   end
endmodule
`default_nettype wire
